// ==== include/dram_cycle_consts.svh ====
`ifndef DRAM_CYCLE_CONSTS_SVH
`define DRAM_CYCLE_CONSTS_SVH

// Number of identical row strobe copies driven for load sharing.
`define ROW_STROBE_COPIES   4
`define ROW_STROBE_ALL_OFF  4'hF
`define ROW_STROBE_ALL_ON   4'h0

// Reset, idle and asserted levels of the single-bit outputs.
`define STROBE_N_OFF        1'h1
`define STROBE_N_ON         1'h0
`define FLAG_CLEAR          1'h0
`define FLAG_SET            1'h1
`define PRECHARGE_RESET     1'h1

// Timing that the outside refresh counter keeps, in its own unit.
`define CORE_CLK_PERIOD_NS  100
`define REFRESH_INTERVAL_NS 15600
`define REFRESH_INTERVAL_CYC (`REFRESH_INTERVAL_NS / `CORE_CLK_PERIOD_NS)

`endif

// ==== include/dram_cycle_pkg.sv ====
`default_nettype none

package dram_cycle_pkg;

   typedef struct packed {
      logic addr_strobe_n;
      logic addr_hold;
      logic burst_ready_n;
      logic burst_last_n;
      logic bus_backoff_n;
   } cpu_bus_s;

   typedef struct packed {
      logic dram_select_n;
      logic write_done_ready_n;
      logic row_match_n;
      logic write_pending_n;
   } dram_status_s;

   typedef enum logic [1:0] {CA_IDLE, CA_START, CA_DRAM, CA_WMISS} ca_state_e;
   typedef enum logic [1:0] {AL_IDLE, AL_HOLD, AL_WMISS} al_state_e;
   typedef enum logic [2:0] {
      PC_READY, PC_ACTIVE, PC_PRECH, PC_REF_A, PC_REF_B
   } pc_state_e;
   typedef enum logic [2:0] {
      RS_IDLE, RS_ACTIVE, RS_MISS, RS_REF_A, RS_REF_B
   } rs_state_e;

endpackage

`default_nettype wire

// ==== rtl/dram_cycle_tracking_row_strobe.sv ====
// Operation
// - Cycle active rises when address strobe or pending flag is sampled.
// - No DRAM select in the clock after start returns to idle.
// - DRAM cycle ends on write ready, burst ready with last, or backoff.
// - Address hold with address strobe keeps the machine idle.
// - Write ready with row strobe on and row mismatch enters write miss.
// - During write miss any starting processor cycle is tracked.
// - One cycle arriving while busy or refreshing is held pending.
// - Pending flag clears once cycle active shows without write miss.
// - Latch hold rises on address strobe, drops off DRAM or at end.
// - Write miss keeps latch hold until the precharge flag drops, then re-arms.
// - Precharge flag follows row strobe; miss gives two clocks precharge.
// - Row strobe drops only for page miss, refresh or reset.
// - Precharge enters refresh timing on strobe off with entry flag.
// - Refresh request sampled at cycle end or idle, never in write miss.
// - Refresh grant drops after the row strobe goes off for refresh.
// - Four identical row strobe copies serve both banks.
// - Row strobe asserts on cycle active, DRAM select and precharge flag.
// - Page miss removes the strobe only inside an active DRAM cycle.
// - After a miss the strobe waits for the precharge flag.
// - Write miss restart uses combined write pending and select term.
// - Grant enters refresh; strobe goes off, then on in RS_REF_B; idle path also refreshes.
// - Grant waits while write pending is active.
// - Cycles starting between request sampling and grant wait for refresh end.
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "dram_cycle_consts.svh"

module dram_cycle_tracking_row_strobe (
   // Clock and reset
   input  wire logic                     CORE_CLK,
   input  wire logic                     RESET,
   // Processor bus
   input  wire dram_cycle_pkg::cpu_bus_s CPU_BUS,
   // Decode, row compare and write engine
   input  wire dram_cycle_pkg::dram_status_s DRAM_STATUS,
   // Refresh counter handshake
   input  wire logic                     REFRESH_REQUEST,
   output var  logic                     REFRESH_GRANT,
   // Cycle tracking
   output var  logic                     CYCLE_ACTIVE_N,
   output var  logic                     WRITE_MISS_N,
   output var  logic                     PENDING_CYCLE_FLAG,
   output var  logic                     ADDR_LATCH_HOLD,
   // Row strobe timing
   output var  logic                     PRECHARGE_FLAG,
   output var  logic                     REFRESH_ENTRY_FLAG,
   output var  logic [`ROW_STROBE_COPIES-1:0] ROW_STROBE_N
);
   import dram_cycle_pkg::*;

   ca_state_e ca_state_r;
   ca_state_e ca_state_nxt;
   al_state_e al_state_r;
   al_state_e al_state_nxt;
   pc_state_e pc_state_r;
   pc_state_e pc_state_nxt;
   rs_state_e rs_state_r;
   rs_state_e rs_state_nxt;
   logic      pending_nxt;
   logic      armed_r;
   logic      armed_nxt;
   logic      grant_nxt;
   logic      start_now;
   logic      ends_now;
   logic      wmiss_now;
   logic      cycle_active;
   logic      in_dram;
   logic      write_miss;
   logic      dram_sel;
   logic      rs_on;
   logic      refresh_states;
   logic      hold_off;
   logic      sel_wip_n;
   logic      sample_refresh;
   logic      rs_miss_now;

   function automatic logic start_seen(input cpu_bus_s bus);
      return !bus.addr_strobe_n && !bus.addr_hold;
   endfunction

   function automatic logic cycle_ends(input cpu_bus_s     bus,
                                       input dram_status_s st);
      return !st.write_done_ready_n ||
             (!bus.burst_ready_n && !bus.burst_last_n) ||
             !bus.bus_backoff_n;
   endfunction

   function automatic logic write_miss_seen(input dram_status_s st,
                                            input logic         on);
      return !st.write_done_ready_n && on && st.row_match_n;
   endfunction

   assign start_now      = start_seen(CPU_BUS);
   assign ends_now       = cycle_ends(CPU_BUS, DRAM_STATUS);
   assign wmiss_now      = write_miss_seen(DRAM_STATUS, rs_on);
   assign cycle_active   = (ca_state_r != CA_IDLE);
   assign in_dram        = (ca_state_r == CA_START) ||
                           (ca_state_r == CA_DRAM);
   assign write_miss     = (ca_state_r == CA_WMISS);
   assign dram_sel       = !DRAM_STATUS.dram_select_n;
   assign rs_on          = (ROW_STROBE_N == `ROW_STROBE_ALL_ON);
   assign refresh_states = (rs_state_r == RS_REF_A) ||
                           (rs_state_r == RS_REF_B);
   // A cycle that starts while refresh is armed, granted or running must not
   // open a row, so the tracker parks it instead.
   assign hold_off       = armed_r || REFRESH_GRANT || refresh_states;
   assign sel_wip_n      = DRAM_STATUS.write_pending_n |
                           DRAM_STATUS.dram_select_n;

   // Cycle-active machine.
   always_comb
   begin
      ca_state_nxt = ca_state_r;
      case (ca_state_r)
         CA_IDLE:
         begin
            if ((start_now || PENDING_CYCLE_FLAG) && !hold_off)
            begin
               ca_state_nxt = CA_START;
            end
         end
         CA_START:
         begin
            if (!dram_sel)
            begin
               ca_state_nxt = CA_IDLE;
            end
            else if (wmiss_now)
            begin
               ca_state_nxt = CA_WMISS;
            end
            else if (ends_now)
            begin
               ca_state_nxt = CA_IDLE;
            end
            else
            begin
               ca_state_nxt = CA_DRAM;
            end
         end
         CA_DRAM:
         begin
            if (wmiss_now)
            begin
               ca_state_nxt = CA_WMISS;
            end
            else if (ends_now)
            begin
               ca_state_nxt = CA_IDLE;
            end
         end
         CA_WMISS:
         begin
            // The write miss is over once the new row is open again.
            if (rs_state_r == RS_ACTIVE)
            begin
               ca_state_nxt = CA_IDLE;
            end
         end
         default:
         begin
            ca_state_nxt = CA_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         ca_state_r     <= CA_IDLE;
         CYCLE_ACTIVE_N <= `STROBE_N_OFF;
         WRITE_MISS_N   <= `STROBE_N_OFF;
      end
      else
      begin
         ca_state_r     <= ca_state_nxt;
         CYCLE_ACTIVE_N <= (ca_state_nxt == CA_IDLE);
         WRITE_MISS_N   <= (ca_state_nxt != CA_WMISS);
      end
   end

   // Pending-cycle tracker. Only one cycle can be parked because the
   // processor does not issue a second strobe before the first is ready.
   always_comb
   begin
      pending_nxt = PENDING_CYCLE_FLAG;
      if (start_now && (cycle_active || hold_off))
      begin
         pending_nxt = `FLAG_SET;
      end
      else if (cycle_active && !write_miss)
      begin
         pending_nxt = `FLAG_CLEAR;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         PENDING_CYCLE_FLAG <= `FLAG_CLEAR;
      end
      else
      begin
         PENDING_CYCLE_FLAG <= pending_nxt;
      end
   end

   // Address-latch-hold machine.
   always_comb
   begin
      al_state_nxt = al_state_r;
      case (al_state_r)
         AL_IDLE:
         begin
            if (start_now || (PENDING_CYCLE_FLAG && dram_sel))
            begin
               al_state_nxt = AL_HOLD;
            end
         end
         AL_HOLD:
         begin
            if ((ca_state_r == CA_START) && !dram_sel)
            begin
               al_state_nxt = AL_IDLE;
            end
            else if (in_dram && wmiss_now)
            begin
               al_state_nxt = AL_WMISS;
            end
            else if (in_dram && ends_now)
            begin
               al_state_nxt = AL_IDLE;
            end
         end
         AL_WMISS:
         begin
            if (cycle_active && !PRECHARGE_FLAG)
            begin
               al_state_nxt = AL_IDLE;
            end
         end
         default:
         begin
            al_state_nxt = AL_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         al_state_r      <= AL_IDLE;
         ADDR_LATCH_HOLD <= `FLAG_CLEAR;
      end
      else
      begin
         al_state_r      <= al_state_nxt;
         ADDR_LATCH_HOLD <= (al_state_nxt != AL_IDLE);
      end
   end

   // Refresh arbitration. The request is looked at only where no write
   // miss can still need the open row.
   assign sample_refresh = (!cycle_active && !start_now &&
                            !PENDING_CYCLE_FLAG) ||
                           (in_dram && dram_sel && ends_now &&
                            !wmiss_now);

   always_comb
   begin
      armed_nxt = armed_r;
      grant_nxt = REFRESH_GRANT;
      if (armed_r && !DRAM_STATUS.write_pending_n)
      begin
         armed_nxt = armed_r;
      end
      else if (armed_r)
      begin
         armed_nxt = `FLAG_CLEAR;
         grant_nxt = `FLAG_SET;
      end
      else if (REFRESH_REQUEST && sample_refresh && !REFRESH_GRANT &&
               !refresh_states)
      begin
         armed_nxt = `FLAG_SET;
      end
      if (REFRESH_GRANT && (rs_state_r == RS_REF_A))
      begin
         grant_nxt = `FLAG_CLEAR;
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         armed_r       <= `FLAG_CLEAR;
         REFRESH_GRANT <= `FLAG_CLEAR;
      end
      else
      begin
         armed_r       <= armed_nxt;
         REFRESH_GRANT <= grant_nxt;
      end
   end

   // Precharge and refresh timing machine.
   always_comb
   begin
      pc_state_nxt = pc_state_r;
      case (pc_state_r)
         PC_READY:
         begin
            if (rs_on)
            begin
               pc_state_nxt = PC_ACTIVE;
            end
            else if (REFRESH_ENTRY_FLAG)
            begin
               pc_state_nxt = PC_REF_A;
            end
         end
         PC_ACTIVE:
         begin
            // Leaving on the removal edge itself keeps the miss precharge
            // at two clocks instead of three.
            if (rs_miss_now)
            begin
               pc_state_nxt = PC_PRECH;
            end
            else if (!rs_on && REFRESH_ENTRY_FLAG)
            begin
               pc_state_nxt = PC_REF_A;
            end
            else if (!rs_on)
            begin
               pc_state_nxt = PC_PRECH;
            end
         end
         PC_PRECH:
         begin
            pc_state_nxt = PC_READY;
         end
         PC_REF_A:
         begin
            pc_state_nxt = PC_REF_B;
         end
         PC_REF_B:
         begin
            pc_state_nxt = PC_PRECH;
         end
         default:
         begin
            pc_state_nxt = PC_READY;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         pc_state_r     <= PC_READY;
         PRECHARGE_FLAG <= `PRECHARGE_RESET;
      end
      else
      begin
         pc_state_r     <= pc_state_nxt;
         PRECHARGE_FLAG <= (pc_state_nxt == PC_READY) ||
                           (pc_state_nxt == PC_ACTIVE);
      end
   end

   // Row strobe machine.
   assign rs_miss_now = (rs_state_r == RS_ACTIVE) && !REFRESH_GRANT &&
                        cycle_active && !write_miss && dram_sel &&
                        DRAM_STATUS.row_match_n;

   always_comb
   begin
      rs_state_nxt = rs_state_r;
      case (rs_state_r)
         RS_IDLE:
         begin
            if (REFRESH_GRANT)
            begin
               rs_state_nxt = RS_REF_A;
            end
            else if (cycle_active && dram_sel && PRECHARGE_FLAG)
            begin
               rs_state_nxt = RS_ACTIVE;
            end
         end
         RS_ACTIVE:
         begin
            if (REFRESH_GRANT)
            begin
               rs_state_nxt = RS_REF_A;
            end
            else if (rs_miss_now)
            begin
               rs_state_nxt = RS_MISS;
            end
         end
         RS_MISS:
         begin
            if (REFRESH_GRANT)
            begin
               rs_state_nxt = RS_REF_A;
            end
            else if (PRECHARGE_FLAG && write_miss && !sel_wip_n)
            begin
               rs_state_nxt = RS_ACTIVE;
            end
            else if (PRECHARGE_FLAG && !write_miss && cycle_active &&
                     dram_sel)
            begin
               rs_state_nxt = RS_ACTIVE;
            end
         end
         RS_REF_A:
         begin
            if (pc_state_r == PC_REF_A)
            begin
               rs_state_nxt = RS_REF_B;
            end
         end
         RS_REF_B:
         begin
            // The row is left closed so the next cycle opens a fresh one.
            if (pc_state_r == PC_PRECH)
            begin
               rs_state_nxt = RS_IDLE;
            end
         end
         default:
         begin
            rs_state_nxt = RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RESET)
      begin
         rs_state_r         <= RS_IDLE;
         REFRESH_ENTRY_FLAG <= `FLAG_CLEAR;
         ROW_STROBE_N       <= `ROW_STROBE_ALL_OFF;
      end
      else
      begin
         rs_state_r         <= rs_state_nxt;
         REFRESH_ENTRY_FLAG <= (rs_state_nxt == RS_REF_A) ||
                               (rs_state_nxt == RS_REF_B);
         if ((rs_state_nxt == RS_ACTIVE) || (rs_state_nxt == RS_REF_B))
         begin
            ROW_STROBE_N <= `ROW_STROBE_ALL_ON;
         end
         else
         begin
            ROW_STROBE_N <= `ROW_STROBE_ALL_OFF;
         end
      end
   end

endmodule

`default_nettype wire

// ==== bench/dram_cycle_tracking_row_strobe_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dram_cycle_consts.svh"
module dram_cycle_checker (
   // Clock and reset
   input wire logic                         CORE_CLK,
   input wire logic                         RESET,
   // Block inputs
   input wire dram_cycle_pkg::cpu_bus_s     CPU_BUS,
   input wire dram_cycle_pkg::dram_status_s DRAM_STATUS,
   input wire logic                         REFRESH_REQUEST,
   // Block outputs
   input wire logic                         REFRESH_GRANT,
   input wire logic                         CYCLE_ACTIVE_N,
   input wire logic                         WRITE_MISS_N,
   input wire logic                         PENDING_CYCLE_FLAG,
   input wire logic                         ADDR_LATCH_HOLD,
   input wire logic                         PRECHARGE_FLAG,
   input wire logic                         REFRESH_ENTRY_FLAG,
   input wire logic [`ROW_STROBE_COPIES-1:0] ROW_STROBE_N
);
   import dram_cycle_pkg::*;
   wire as_on  = !CPU_BUS.addr_strobe_n;
   wire ca     = !CYCLE_ACTIVE_N;
   wire wm     = !WRITE_MISS_N;
   wire miss   = DRAM_STATUS.row_match_n;
   wire row_on = ROW_STROBE_N == `ROW_STROBE_ALL_ON;
   wire ends   = !CPU_BUS.burst_ready_n && !CPU_BUS.burst_last_n
                 || !CPU_BUS.bus_backoff_n;
   // A strobe must open a cycle whenever nothing, refresh included, is busy.
   wire free   = !ca && !PENDING_CYCLE_FLAG && !REFRESH_REQUEST
                 && !REFRESH_GRANT && !REFRESH_ENTRY_FLAG;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   property p_copies;
      row_on || ROW_STROBE_N == `ROW_STROBE_ALL_OFF;
   endproperty
   a_copies: assert property (p_copies)
      else $error("row strobe copies differ");
   property p_start;
      as_on && !CPU_BUS.addr_hold && free |=> ca;
   endproperty
   a_start: assert property (p_start)
      else $error("cycle did not start");
   property p_hold;
      as_on && CPU_BUS.addr_hold && !ca && !PENDING_CYCLE_FLAG |=> !ca;
   endproperty
   a_hold: assert property (p_hold)
      else $error("cycle started under address hold");
   property p_non_dram;
      $fell(CYCLE_ACTIVE_N) && !wm && DRAM_STATUS.dram_select_n |=> !ca;
   endproperty
   a_non_dram: assert property (p_non_dram)
      else $error("non-memory cycle kept active");
   property p_end;
      ca && !wm && !$fell(CYCLE_ACTIVE_N) && ends |=> !ca;
   endproperty
   a_end: assert property (p_end)
      else $error("cycle did not end");
   property p_drop;
      $rose(ROW_STROBE_N[0]) |-> $past(miss) || $past(REFRESH_GRANT)
         || $past(REFRESH_ENTRY_FLAG);
   endproperty
   a_drop: assert property (p_drop)
      else $error("row strobe dropped without cause");
   property p_prech;
      $rose(ROW_STROBE_N[0]) && !REFRESH_ENTRY_FLAG
         && !$past(REFRESH_ENTRY_FLAG) |-> !PRECHARGE_FLAG
         ##1 (PRECHARGE_FLAG && !row_on && ROW_STROBE_N[0]);
   endproperty
   a_prech: assert property (p_prech)
      else $error("miss precharge timing wrong");
   property p_grant;
      $rose(REFRESH_GRANT) |=> REFRESH_ENTRY_FLAG ##[1:2] !REFRESH_GRANT;
   endproperty
   a_grant: assert property (p_grant)
      else $error("refresh grant not withdrawn");
   property p_wmiss;
      ca && !wm && !DRAM_STATUS.write_done_ready_n && row_on && miss |=> wm;
   endproperty
   a_wmiss: assert property (p_wmiss)
      else $error("write miss not entered");
endmodule

bind dram_cycle_tracking_row_strobe dram_cycle_checker chk (
   .CORE_CLK, .RESET, .CPU_BUS, .DRAM_STATUS, .REFRESH_REQUEST,
   .REFRESH_GRANT, .CYCLE_ACTIVE_N, .WRITE_MISS_N, .PENDING_CYCLE_FLAG,
   .ADDR_LATCH_HOLD, .PRECHARGE_FLAG, .REFRESH_ENTRY_FLAG, .ROW_STROBE_N
);
`default_nettype wire

// ==== bench/dram_refresh_source.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dram_cycle_consts.svh"
module dram_refresh_source #(
   parameter int INTERVAL = `REFRESH_INTERVAL_CYC
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Handshake with the controller
   input  wire logic enable,
   input  wire logic grant,
   output logic      request
);
   int count_r;
   // The request is held until granted, so a slow grant loses no refresh.
   always_ff @(posedge clk)
   begin
      if (rst || !enable)
      begin
         count_r <= 0;
         request <= 1'h0;
      end
      else if (request)
         request <= !grant;
      else if (count_r == INTERVAL - 1)
      begin
         count_r <= 0;
         request <= 1'h1;
      end
      else
         count_r <= count_r + 1;
   end
endmodule
`default_nettype wire

// ==== bench/dram_cycle_tracking_row_strobe_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module dram_cycle_tracking_row_strobe_tb_top;
   import dram_cycle_pkg::*;
   logic         core_clk;
   logic         reset;
   cpu_bus_s     cpu;
   dram_status_s st;
   logic         ref_en;
   logic         req;
   logic         grant;
   logic         ca_n;
   logic         wm_n;
   logic         pend;
   logic         addr_latch_hold;
   logic         prech;
   logic         entry;
   logic [3:0]   row_n;
   int           miscompares;
   int           checks_done;
   int           cycles;

   dram_cycle_tracking_row_strobe uut (
      .CORE_CLK(core_clk), .RESET(reset), .CPU_BUS(cpu),
      .DRAM_STATUS(st), .REFRESH_REQUEST(req), .REFRESH_GRANT(grant),
      .CYCLE_ACTIVE_N(ca_n), .WRITE_MISS_N(wm_n),
      .PENDING_CYCLE_FLAG(pend), .ADDR_LATCH_HOLD(addr_latch_hold),
      .PRECHARGE_FLAG(prech), .REFRESH_ENTRY_FLAG(entry),
      .ROW_STROBE_N(row_n)
   );
   dram_refresh_source #(.INTERVAL(40)) far (
      .clk(core_clk), .rst(reset), .enable(ref_en), .grant(grant),
      .request(req)
   );

   initial
   begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end

   task report_and_stop;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         report_and_stop;
      end
   end

   task chk4(input logic [3:0] got, input logic [3:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask

   task chk1(input logic got, input logic exp);
      chk4({3'h0, got}, {3'h0, exp});
   endtask

   function logic pick(input int which);
      case (which)
         0: return pend;
         1: return grant;
         2: return entry;
         3: return req;
         default: return ca_n;
      endcase
   endfunction

   task wait_lvl(input int which, input logic lvl);
      int n;
      n = 0;
      while (pick(which) !== lvl && n < 60)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk1(pick(which), lvl);
   endtask

   task start(input logic sel_n, hold, miss_n, wr);
      @(posedge core_clk);
      cpu.addr_strobe_n <= 1'h0;
      cpu.addr_hold <= hold;
      st.dram_select_n <= sel_n;
      st.row_match_n <= miss_n;
      @(posedge core_clk);
      cpu.addr_strobe_n <= 1'h1;
      cpu.addr_hold <= 1'h0;
      st.write_done_ready_n <= !wr;
      #1;
   endtask

   task finish(input logic abort);
      @(posedge core_clk);
      cpu.bus_backoff_n <= !abort;
      cpu.burst_ready_n <= abort;
      cpu.burst_last_n <= abort;
      @(posedge core_clk);
      cpu <= 5'h17;
      #1;
      chk4({ca_n, addr_latch_hold, 2'h0}, 4'h8);
   endtask

   task t_hit;
      start(1'h0, 1'h0, 1'h0, 1'h0);
      chk4({ca_n, addr_latch_hold, 2'h0}, 4'h4);
      @(posedge core_clk);
      #1;
      chk4(row_n, 4'h0);
      finish(1'h0);
      chk4(row_n, 4'h0);
      $display("read hit done");
   endtask

   task t_other;
      start(1'h1, 1'h0, 1'h1, 1'h0);
      chk1(ca_n, 1'h0);
      @(posedge core_clk);
      #1;
      chk4({ca_n, addr_latch_hold, 2'h0}, 4'h8);
      chk4(row_n, 4'h0);
      start(1'h0, 1'h1, 1'h0, 1'h0);
      chk4({ca_n, pend, 2'h0}, 4'h8);
      @(posedge core_clk);
      #1;
      chk1(ca_n, 1'h1);
      $display("non-memory and hold done");
   endtask

   task t_read_miss;
      start(1'h0, 1'h0, 1'h1, 1'h0);
      @(posedge core_clk);
      #1;
      chk4({row_n[0], prech, 2'h0}, 4'h8);
      @(posedge core_clk);
      st.row_match_n <= 1'h0;
      #1;
      chk4({row_n[0], prech, 2'h0}, 4'hC);
      @(posedge core_clk);
      #1;
      chk4(row_n, 4'h0);
      finish(1'h0);
      $display("read miss done");
   endtask

   task t_write_miss;
      @(posedge core_clk);
      st.write_pending_n <= 1'h0;
      start(1'h0, 1'h0, 1'h1, 1'h1);
      chk1(ca_n, 1'h0);
      @(posedge core_clk);
      st.write_done_ready_n <= 1'h1;
      cpu.addr_strobe_n <= 1'h0;
      #1;
      chk4({wm_n, ca_n, prech, addr_latch_hold}, 4'h1);
      chk4(row_n, 4'hF);
      @(posedge core_clk);
      cpu.addr_strobe_n <= 1'h1;
      st.row_match_n <= 1'h0;
      #1;
      chk4({pend, prech, 2'h0}, 4'hC);
      @(posedge core_clk);
      st.write_pending_n <= 1'h1;
      #1;
      chk4(row_n, 4'h0);
      wait_lvl(0, 1'h0);
      chk4({ca_n, wm_n, addr_latch_hold, 1'h0}, 4'h6);
      finish(1'h1);
      $display("write miss done");
   endtask

   task t_refresh;
      @(posedge core_clk);
      ref_en <= 1'h1;
      st.write_pending_n <= 1'h0;
      wait_lvl(3, 1'h1);
      @(posedge core_clk);
      start(1'h0, 1'h0, 1'h0, 1'h0);
      chk4({ca_n, pend, 2'h0}, 4'hC);
      repeat (3) @(posedge core_clk);
      st.write_pending_n <= 1'h1;
      #1;
      chk1(grant, 1'h0);
      wait_lvl(1, 1'h1);
      @(posedge core_clk);
      #1;
      chk4({entry, ca_n, row_n[0], 1'h0}, 4'hE);
      wait_lvl(1, 1'h0);
      chk1(req, 1'h0);
      chk1(prech, 1'h0);
      wait_lvl(2, 1'h0);
      chk4(row_n, 4'hF);
      wait_lvl(4, 1'h0);
      finish(1'h0);
      @(posedge core_clk);
      ref_en <= 1'h0;
      $display("refresh done");
   endtask

   initial
   begin
      reset = 1'h1;
      cpu = 5'h17;
      st = 4'hD;
      ref_en = 1'h0;
      repeat (10) @(posedge core_clk);
      reset <= 1'h0;
      #1;
      chk4({ca_n, wm_n, pend, addr_latch_hold}, 4'hC);
      chk4({prech, grant, entry, 1'h0}, 4'h8);
      chk4(row_n, 4'hF);
      t_hit();
      t_other();
      t_read_miss();
      t_write_miss();
      t_refresh();
      report_and_stop;
   end
endmodule
`default_nettype wire
